/* File: include/stsm_map.svh */
// stsm_map.svh: constants for target status and message control
// assumes: included by bare name from the rtl and testbench files
`ifndef STSM_MAP_SVH
`define STSM_MAP_SVH
// status byte codes
`define STSM_ST_GOOD 8'h00
`define STSM_ST_CHECK 8'h02
`define STSM_ST_BUSY 8'h08
`define STSM_ST_RESV 8'h18
// message codes
`define STSM_MSG_CMD_DONE 8'h00
`define STSM_MSG_SAVE_PTR 8'h02
`define STSM_MSG_RESTORE 8'h03
`define STSM_MSG_DISCON 8'h04
`define STSM_MSG_INIT_ERR 8'h05
`define STSM_MSG_ABORT 8'h06
`define STSM_MSG_REJECT 8'h07
`define STSM_MSG_NOP 8'h08
`define STSM_MSG_PARITY 8'h09
`define STSM_MSG_DEV_RESET 8'h0C
`define STSM_MSG_IDENT_BIT 7
`endif

/* File: include/stsm_pkg.sv */
// stsm_pkg: types for target status and message control
// assumes: nothing beyond the map header
package stsm_pkg;
  typedef enum logic [3:0] {
    STSM_FREE = 4'h0,
    STSM_SEL = 4'h1,
    STSM_CMD = 4'h2,
    STSM_DOUT = 4'h3,
    STSM_DIN = 4'h4,
    STSM_STAT = 4'h5,
    STSM_MOUT = 4'h6,
    STSM_MIN = 4'h7
  } stsm_phase_type;
  typedef enum logic [3:0] {
    STSM_K_NONE = 4'h0,
    STSM_K_CMD_DONE = 4'h1,
    STSM_K_SAVE_PTR = 4'h2,
    STSM_K_RESTORE = 4'h3,
    STSM_K_DISCON = 4'h4,
    STSM_K_INIT_ERR = 4'h5,
    STSM_K_ABORT = 4'h6,
    STSM_K_REJECT = 4'h7,
    STSM_K_NOP = 4'h8,
    STSM_K_PARITY = 4'h9,
    STSM_K_DEV_RESET = 4'hA,
    STSM_K_IDENT = 4'hB,
    STSM_K_UNKNOWN = 4'hC
  } stsm_msg_type;
endpackage : stsm_pkg

/* File: rtl/stsm_msg_decode.sv */
// stsm_msg_decode: classifies a received message byte
// assumes: byte comes from logic on the same clock
`timescale 1ns/100ps
`include "stsm_map.svh"
module stsm_msg_decode (
  input wire logic [7:0] msg_byte,
  output stsm_pkg::stsm_msg_type msg_kind
);
  // ************************************************************
  // message decode
  // ************************************************************
  always_comb begin
    if (msg_byte[`STSM_MSG_IDENT_BIT]) begin
      msg_kind = stsm_pkg::STSM_K_IDENT;
    end else begin
      case (msg_byte)
        `STSM_MSG_CMD_DONE: msg_kind = stsm_pkg::STSM_K_CMD_DONE;
        `STSM_MSG_SAVE_PTR: msg_kind = stsm_pkg::STSM_K_SAVE_PTR;
        `STSM_MSG_RESTORE: msg_kind = stsm_pkg::STSM_K_RESTORE;
        `STSM_MSG_DISCON: msg_kind = stsm_pkg::STSM_K_DISCON;
        `STSM_MSG_INIT_ERR: msg_kind = stsm_pkg::STSM_K_INIT_ERR;
        `STSM_MSG_ABORT: msg_kind = stsm_pkg::STSM_K_ABORT;
        `STSM_MSG_REJECT: msg_kind = stsm_pkg::STSM_K_REJECT;
        `STSM_MSG_NOP: msg_kind = stsm_pkg::STSM_K_NOP;
        `STSM_MSG_PARITY: msg_kind = stsm_pkg::STSM_K_PARITY;
        `STSM_MSG_DEV_RESET: msg_kind = stsm_pkg::STSM_K_DEV_RESET;
        default: msg_kind = stsm_pkg::STSM_K_UNKNOWN;
      endcase
    end
  end
endmodule : stsm_msg_decode

/* File: rtl/stsm_ctrl.sv */
// stsm_ctrl: target status selection, attention sampling, message flow
// assumes: bus handshake engine outside; atn_pin and bus_rst_pin raw pins
// Behaviour
// - good status on successful completion
// - check condition on abnormal end or early error
// - check condition on first select after ready
// - check condition on first select after reset
// - busy status when command cannot be accepted
// - reservation conflict when reserved by other initiator
// - no notice when busy ends; initiator polls
// - sample attention just before phase change
// - check attention after each received message
// - check attention after each sent message
// - attention during image read stops scanning
// - message out only on attention
// - message in allowed after selection completes
// - decode supported message codes
// - command complete queued after every status byte
// - bus free right after command complete
// - reject of command complete still frees bus
// - exactly one status byte per command
// - initiator error: send restore, retry phase
`timescale 1ns/100ps
`include "stsm_map.svh"
module stsm_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic atn_pin,
  input wire logic bus_rst_pin,
  input wire logic selected,
  input wire logic cmd_start,
  input wire logic cmd_ok,
  input wire logic cmd_fail,
  input wire logic early_err,
  input wire logic unit_busy,
  input wire logic resv_other,
  input wire logic unit_ready,
  input wire logic image_read,
  input wire logic [3:0] next_phase,
  input wire logic phase_go,
  input wire logic xfer_done,
  input wire logic [7:0] msg_in_byte,
  input wire logic msg_in_valid,
  output logic [3:0] phase,
  output logic [7:0] status_byte,
  output logic status_valid,
  output logic [7:0] msg_out_byte,
  output logic msg_out_valid,
  output logic scan_stop,
  output logic bus_release,
  output logic atn_seen
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] atn_sync_q;
  logic [2:0] rst_sync_q;
  logic atn_lvl_q;
  logic atn_lvl_d;
  logic brst_lvl_q;
  logic brst_lvl_d;
  always_comb begin
    atn_lvl_d = atn_lvl_q;
    brst_lvl_d = brst_lvl_q;
    if (atn_sync_q[1] == atn_sync_q[2]) begin
      atn_lvl_d = atn_sync_q[2];
    end
    if (rst_sync_q[1] == rst_sync_q[2]) begin
      brst_lvl_d = rst_sync_q[2];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      atn_sync_q <= 3'h0;
      rst_sync_q <= 3'h0;
      atn_lvl_q <= 1'b0;
      brst_lvl_q <= 1'b0;
    end else begin
      atn_sync_q <= {atn_sync_q[1:0], atn_pin};
      rst_sync_q <= {rst_sync_q[1:0], bus_rst_pin};
      atn_lvl_q <= atn_lvl_d;
      brst_lvl_q <= brst_lvl_d;
    end
  end
  // ************************************************************
  // message decode
  // ************************************************************
  stsm_pkg::stsm_msg_type msg_kind;
  stsm_msg_decode u_dec (
    .msg_byte(msg_in_byte),
    .msg_kind(msg_kind)
  );
  // ************************************************************
  // phase sequencer
  // ************************************************************
  stsm_pkg::stsm_phase_type ph_q;
  stsm_pkg::stsm_phase_type ph_d;
  stsm_pkg::stsm_phase_type ret_q;
  stsm_pkg::stsm_phase_type ret_d;
  logic [7:0] st_q;
  logic [7:0] st_d;
  logic st_vld_q;
  logic st_vld_d;
  logic st_sent_q;
  logic st_sent_d;
  logic [7:0] mo_q;
  logic [7:0] mo_d;
  logic mo_vld_q;
  logic mo_vld_d;
  logic done_pend_q;
  logic done_pend_d;
  logic stop_q;
  logic stop_d;
  logic rel_q;
  logic rel_d;
  logic atn_q;
  logic atn_d;
  logic uattn_q;
  logic uattn_d;
  logic rdy_q;
  logic rdy_d;
  logic ok_q;
  logic ok_d;
  function automatic logic [7:0] pick_status(
    input logic busy,
    input logic resv,
    input logic attn,
    input logic fail,
    input logic ok
  );
    if (busy) begin
      pick_status = `STSM_ST_BUSY;
    end else if (resv) begin
      pick_status = `STSM_ST_RESV;
    end else if (attn || fail || !ok) begin
      pick_status = `STSM_ST_CHECK;
    end else begin
      pick_status = `STSM_ST_GOOD;
    end
  endfunction : pick_status
  always_comb begin
    ph_d = ph_q;
    ret_d = ret_q;
    st_d = st_q;
    st_vld_d = 1'b0;
    st_sent_d = st_sent_q;
    mo_d = mo_q;
    mo_vld_d = 1'b0;
    done_pend_d = done_pend_q;
    stop_d = 1'b0;
    rel_d = 1'b0;
    atn_d = 1'b0;
    uattn_d = uattn_q;
    rdy_d = unit_ready;
    ok_d = ok_q;
    if (brst_lvl_q) begin
      uattn_d = 1'b1;
      ph_d = stsm_pkg::STSM_FREE;
    end else begin
      case (ph_q)
        stsm_pkg::STSM_FREE: begin
          if (selected) begin
            ph_d = stsm_pkg::STSM_SEL;
            st_sent_d = 1'b0;
            done_pend_d = 1'b0;
            ok_d = 1'b1;
          end
        end
        stsm_pkg::STSM_MOUT: begin
          if (msg_in_valid) begin
            atn_d = atn_lvl_q;
            case (msg_kind)
              stsm_pkg::STSM_K_INIT_ERR: begin
                mo_d = `STSM_MSG_RESTORE;
                ph_d = stsm_pkg::STSM_MIN;
              end
              stsm_pkg::STSM_K_REJECT: begin
                if (done_pend_q) begin
                  ph_d = stsm_pkg::STSM_FREE;
                  rel_d = 1'b1;
                end else begin
                  ph_d = ret_q;
                end
              end
              stsm_pkg::STSM_K_ABORT: begin
                ph_d = stsm_pkg::STSM_FREE;
                rel_d = 1'b1;
              end
              stsm_pkg::STSM_K_DEV_RESET: begin
                uattn_d = 1'b1;
                ph_d = stsm_pkg::STSM_FREE;
                rel_d = 1'b1;
              end
              stsm_pkg::STSM_K_UNKNOWN: begin
                mo_d = `STSM_MSG_REJECT;
                ph_d = stsm_pkg::STSM_MIN;
              end
              default: begin
                if (!atn_lvl_q) begin
                  ph_d = ret_q;
                end
              end
            endcase
          end
        end
        stsm_pkg::STSM_MIN: begin
          mo_vld_d = !xfer_done;
          if (xfer_done) begin
            atn_d = atn_lvl_q;
            if (mo_q == `STSM_MSG_CMD_DONE && done_pend_q && !atn_lvl_q) begin
              ph_d = stsm_pkg::STSM_FREE;
              rel_d = 1'b1;
            end else if (atn_lvl_q) begin
              ph_d = stsm_pkg::STSM_MOUT;
            end else begin
              ph_d = ret_q;
            end
          end
        end
        default: begin
          // sel, cmd, data and status phases
          if (ph_q == stsm_pkg::STSM_DIN && image_read && atn_lvl_q) begin
            stop_d = 1'b1;
            ok_d = 1'b0;
          end
          if (cmd_fail) begin
            ok_d = 1'b0;
          end
          if (ph_q == stsm_pkg::STSM_SEL && (unit_busy || resv_other
              || early_err)) begin
            // command phase skipped, go straight to status
            ph_d = stsm_pkg::STSM_STAT;
            if (early_err) begin
              ok_d = 1'b0;
            end
          end else if (ph_q == stsm_pkg::STSM_STAT && !st_sent_q) begin
            st_d = pick_status(unit_busy, resv_other, uattn_q,
                               cmd_fail, ok_q && cmd_ok);
            st_vld_d = 1'b1;
            if (xfer_done) begin
              st_sent_d = 1'b1;
              st_vld_d = 1'b0;
              if (st_q == `STSM_ST_CHECK && uattn_q) begin
                uattn_d = 1'b0;
              end
            end
          end else if (ph_q == stsm_pkg::STSM_STAT) begin
            atn_d = atn_lvl_q;
            ret_d = ph_q;
            done_pend_d = 1'b1;
            mo_d = `STSM_MSG_CMD_DONE;
            ph_d = atn_lvl_q ? stsm_pkg::STSM_MOUT : stsm_pkg::STSM_MIN;
          end else if (phase_go) begin
            atn_d = atn_lvl_q;
            ret_d = (next_phase == 4'(stsm_pkg::STSM_MOUT)) ? ph_q
                : stsm_pkg::stsm_phase_type'(next_phase);
            if (atn_lvl_q) begin
              ph_d = stsm_pkg::STSM_MOUT;
            end else if (next_phase == 4'(stsm_pkg::STSM_MOUT)) begin
              ph_d = ph_q;
            end else begin
              ph_d = stsm_pkg::stsm_phase_type'(next_phase);
            end
          end
        end
      endcase
    end
    // ready edge arms the check, after the clear so a set wins
    if (unit_ready && !rdy_q) begin
      uattn_d = 1'b1;
    end
    // busy clears silently, no message queued
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_q <= stsm_pkg::STSM_FREE;
      ret_q <= stsm_pkg::STSM_FREE;
      st_q <= `STSM_ST_GOOD;
      st_vld_q <= 1'b0;
      st_sent_q <= 1'b0;
      mo_q <= `STSM_MSG_CMD_DONE;
      mo_vld_q <= 1'b0;
      done_pend_q <= 1'b0;
      stop_q <= 1'b0;
      rel_q <= 1'b0;
      atn_q <= 1'b0;
      uattn_q <= 1'b1;
      rdy_q <= 1'b0;
      ok_q <= 1'b1;
    end else begin
      ph_q <= ph_d;
      ret_q <= ret_d;
      st_q <= st_d;
      st_vld_q <= st_vld_d;
      st_sent_q <= st_sent_d;
      mo_q <= mo_d;
      mo_vld_q <= mo_vld_d;
      done_pend_q <= done_pend_d;
      stop_q <= stop_d;
      rel_q <= rel_d;
      atn_q <= atn_d;
      uattn_q <= uattn_d;
      rdy_q <= rdy_d;
      ok_q <= ok_d;
    end
  end
  assign phase = ph_q;
  assign status_byte = st_q;
  assign status_valid = st_vld_q;
  assign msg_out_byte = mo_q;
  assign msg_out_valid = mo_vld_q;
  assign scan_stop = stop_q;
  assign bus_release = rel_q;
  assign atn_seen = atn_q;
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_done_frees_bus: assert property (
    (ph_q == stsm_pkg::STSM_MIN && xfer_done && done_pend_q
     && mo_q == `STSM_MSG_CMD_DONE && !atn_lvl_q && !brst_lvl_q)
    |=> (ph_q == stsm_pkg::STSM_FREE && rel_q))
    else $error("bus not freed after command complete");
  chk_status_then_done: assert property (
    (ph_q == stsm_pkg::STSM_STAT && st_sent_q && !brst_lvl_q)
    |=> (mo_q == `STSM_MSG_CMD_DONE && done_pend_q))
    else $error("command complete not queued after status");
  chk_reject_frees: assert property (
    (ph_q == stsm_pkg::STSM_MOUT && msg_in_valid && done_pend_q
     && msg_kind == stsm_pkg::STSM_K_REJECT && !brst_lvl_q)
    |=> ph_q == stsm_pkg::STSM_FREE)
    else $error("reject of complete did not free bus");
  chk_scan_stop: assert property (
    (ph_q == stsm_pkg::STSM_DIN && image_read && atn_lvl_q && !brst_lvl_q)
    |=> scan_stop)
    else $error("scan not stopped on attention");
  chk_busy_code: assert property (
    (st_vld_q && $past(unit_busy)) |-> st_q == `STSM_ST_BUSY)
    else $error("busy code wrong");
  chk_mout_on_atn: assert property (
    (ph_q != stsm_pkg::STSM_MOUT && ph_d == stsm_pkg::STSM_MOUT)
    |-> atn_lvl_q)
    else $error("message out without attention");
  chk_reset_arms: assert property (
    brst_lvl_q |=> uattn_q)
    else $error("bus reset did not arm check");
  chk_reject_unknown: assert property (
    (ph_q == stsm_pkg::STSM_MOUT && msg_in_valid && !brst_lvl_q
     && msg_kind == stsm_pkg::STSM_K_UNKNOWN)
    |=> (ph_q == stsm_pkg::STSM_MIN && mo_q == `STSM_MSG_REJECT))
    else $error("unknown message not rejected");
  chk_restore_reply: assert property (
    (ph_q == stsm_pkg::STSM_MOUT && msg_in_valid && !brst_lvl_q
     && msg_kind == stsm_pkg::STSM_K_INIT_ERR)
    |=> mo_q == `STSM_MSG_RESTORE)
    else $error("restore pointers not sent");
  cov_good_end: cover property (st_vld_q && st_q == `STSM_ST_GOOD);
  cov_check_end: cover property (st_vld_q && st_q == `STSM_ST_CHECK);
  cov_release: cover property (rel_q);
  cov_stop: cover property (scan_stop);
endmodule : stsm_ctrl

/* File: sim/stsm_init_model.sv */
// stsm_init_model: initiator side of the status and message handshake
// assumes: driven from the bench clock; acks land at the falling edge
`timescale 1ns/100ps
module stsm_init_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic status_valid,
  input wire logic msg_out_valid,
  input wire logic [1:0] lag,
  input wire logic want_msg,
  output logic atn_pin,
  output logic xfer_done
);
  // ****************************************
  // handshake
  // ****************************************
  int wait_n = 0;
  initial xfer_done = 1'h0;
  // attention only when a message is pending
  assign atn_pin = want_msg;
  // ack each byte after a lag; the ack drops again on the next falling edge
  always @(negedge clk) begin
    if (sys_rst || xfer_done) begin
      xfer_done <= 1'h0;
      wait_n <= 0;
    end else if (status_valid || msg_out_valid) begin
      if (wait_n >= int'(lag)) xfer_done <= 1'h1;
      else wait_n <= wait_n + 1;
    end
  end
endmodule : stsm_init_model

/* File: sim/testbench.sv */
// testbench: status selection, attention and message flow of stsm_ctrl
// assumes: stsm_pkg compiled first; stsm_map.svh on the include path
`timescale 1ns/100ps
`include "stsm_map.svh"
module testbench;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic want_msg = 1'h0, bus_rst_pin = 1'h0, selected = 1'h0;
  logic cmd_ok = 1'h0, cmd_fail = 1'h0, early_err = 1'h0;
  logic unit_busy = 1'h0, resv_other = 1'h0, unit_ready = 1'h1;
  logic image_read = 1'h0, phase_go = 1'h0, msg_in_valid = 1'h0;
  logic [3:0] next_phase = 4'h0;
  logic [7:0] msg_in_byte = 8'hFF;
  logic [1:0] lag = 2'h0;
  logic [3:0] phase;
  logic [7:0] status_byte, msg_out_byte, got, code, rnd;
  logic status_valid, msg_out_valid, scan_stop, bus_release, atn_seen;
  logic atn_pin, xfer_done;
  logic quiet = 1'h0, rel_seen = 1'h0, stop_seen = 1'h0, atn_hit = 1'h0;
  logic [7:0] expq[$];
  int fails = 0, compares = 0, tests = 0, seed = 32'h17be;

  always #4 clk = ~clk;

  stsm_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .atn_pin(atn_pin),
    .bus_rst_pin(bus_rst_pin), .selected(selected), .cmd_start(1'h0),
    .cmd_ok(cmd_ok), .cmd_fail(cmd_fail), .early_err(early_err),
    .unit_busy(unit_busy), .resv_other(resv_other),
    .unit_ready(unit_ready), .image_read(image_read),
    .next_phase(next_phase), .phase_go(phase_go), .xfer_done(xfer_done),
    .msg_in_byte(msg_in_byte), .msg_in_valid(msg_in_valid),
    .phase(phase), .status_byte(status_byte),
    .status_valid(status_valid), .msg_out_byte(msg_out_byte),
    .msg_out_valid(msg_out_valid), .scan_stop(scan_stop),
    .bus_release(bus_release), .atn_seen(atn_seen));

  stsm_init_model INIT (.clk(clk), .sys_rst(sys_rst),
    .status_valid(status_valid), .msg_out_valid(msg_out_valid),
    .lag(lag), .want_msg(want_msg), .atn_pin(atn_pin),
    .xfer_done(xfer_done));

  // ****************************************
  // checking
  // ****************************************
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // each acked byte is matched against the oldest note
  always @(posedge clk) begin
    if (bus_release === 1'h1) rel_seen <= 1'h1;
    if (scan_stop === 1'h1) stop_seen <= 1'h1;
    if (atn_seen === 1'h1) atn_hit <= 1'h1;
    if (xfer_done === 1'h1 && !quiet &&
        (status_valid === 1'h1 || msg_out_valid === 1'h1)) begin
      got = (status_valid === 1'h1) ? status_byte : msg_out_byte;
      if (expq.size() == 0) check(got, ~got);
      else check(got, expq.pop_front());
    end
  end

  // ****************************************
  // drivers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic timeout();
    check(8'(phase), 8'hEE);
    complete_run();
  endtask : timeout

  task automatic wait_phase(input logic [3:0] p);
    int i;
    for (i = 0; i < 40 && phase !== p; i++) tick(1);
    if (phase !== p) timeout();
  endtask : wait_phase

  task automatic go(input logic [3:0] p);
    next_phase = p;
    phase_go = 1'h1;
    tick(1);
    phase_go = 1'h0;
  endtask : go

  task automatic start_cmd(input logic ok, fail, early, busy, resv);
    cmd_ok = ok;
    early_err = early;
    unit_busy = busy;
    resv_other = resv;
    lag = 2'($random(seed));
    selected = 1'h1;
    tick(1);
    selected = 1'h0;
    wait_phase(stsm_pkg::STSM_SEL);
    cmd_fail = fail;
    tick(1);
    cmd_fail = 1'h0;
  endtask : start_cmd

  task automatic finish_cmd(input logic [7:0] exp);
    expq.push_back(exp);
    expq.push_back(`STSM_MSG_CMD_DONE);
    rel_seen = 1'h0;
    go(stsm_pkg::STSM_STAT);
    wait_phase(stsm_pkg::STSM_FREE);
    tick(2);
    check({7'h0, rel_seen}, 8'h01);
    check(8'(expq.size()), 8'h00);
    {cmd_ok, early_err, unit_busy, resv_other} = 4'h0;
    end_test();
  endtask : finish_cmd

  task automatic end_test();
    tests++;
    $display("test %0d done at %0t", tests, $time);
  endtask : end_test

  task automatic put_msg(input logic [7:0] c);
    msg_in_byte = c;
    msg_in_valid = 1'h1;
    tick(1);
    msg_in_valid = 1'h0;
    msg_in_byte = ~c;
  endtask : put_msg

  task automatic run_cmd(input logic ok, fail, early, busy, resv,
                         input logic [7:0] exp);
    start_cmd(ok, fail, early, busy, resv);
    finish_cmd(exp);
  endtask : run_cmd

  task automatic send_msg(input logic [7:0] c, input logic [7:0] reply);
    int i;
    if (phase !== stsm_pkg::STSM_MOUT) go(stsm_pkg::STSM_MOUT);
    wait_phase(stsm_pkg::STSM_MOUT);
    expq.push_back(reply);
    put_msg(c);
    for (i = 0; i < 40 && (expq.size() != 0 ||
         phase === stsm_pkg::STSM_MIN); i++) tick(1);
    if (i == 40) timeout();
  endtask : send_msg

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    tick(16);
    sys_rst = 1'h0;
    run_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, `STSM_ST_CHECK);
    run_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, `STSM_ST_GOOD);
    run_cmd(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, `STSM_ST_CHECK);
    run_cmd(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, `STSM_ST_CHECK);
    run_cmd(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, `STSM_ST_BUSY);
    run_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, `STSM_ST_RESV);
    // busy rejected: reissue without any notice
    run_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, `STSM_ST_GOOD);
    unit_ready = 1'h0;
    tick(3);
    unit_ready = 1'h1;
    tick(3);
    run_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, `STSM_ST_CHECK);
    bus_rst_pin = 1'h1;
    tick(6);
    bus_rst_pin = 1'h0;
    tick(6);
    run_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, `STSM_ST_CHECK);
    start_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    go(stsm_pkg::STSM_MOUT);
    tick(3);
    check(8'(phase), 8'(stsm_pkg::STSM_SEL));
    want_msg = 1'h1;
    tick(6);
    rnd = 8'($random(seed));
    code = {1'h0, rnd[6:0]} | 8'h10;
    send_msg(code, `STSM_MSG_REJECT);
    send_msg(`STSM_MSG_INIT_ERR, `STSM_MSG_RESTORE);
    want_msg = 1'h0;
    tick(6);
    put_msg(`STSM_MSG_NOP);
    check(8'(phase), 8'(stsm_pkg::STSM_SEL));
    finish_cmd(`STSM_ST_GOOD);
    // attention before command complete, then a reject frees the bus
    start_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    expq.push_back(`STSM_ST_GOOD);
    lag = 2'h3;
    want_msg = 1'h1;
    rel_seen = 1'h0;
    atn_hit = 1'h0;
    go(stsm_pkg::STSM_STAT);
    wait_phase(stsm_pkg::STSM_MOUT);
    want_msg = 1'h0;
    put_msg(`STSM_MSG_REJECT);
    wait_phase(stsm_pkg::STSM_FREE);
    tick(2);
    check({7'h0, rel_seen}, 8'h01);
    check({7'h0, atn_hit}, 8'h01);
    check(8'(expq.size()), 8'h00);
    end_test();
    start_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    image_read = 1'h1;
    go(stsm_pkg::STSM_DIN);
    wait_phase(stsm_pkg::STSM_DIN);
    stop_seen = 1'h0;
    want_msg = 1'h1;
    tick(6);
    quiet = 1'h1;
    go(stsm_pkg::STSM_STAT);
    tick(12);
    check({7'h0, stop_seen}, 8'h01);
    end_test();
    want_msg = 1'h0;
    image_read = 1'h0;
    sys_rst = 1'h1;
    tick(2);
    sys_rst = 1'h0;
    expq.delete();
    quiet = 1'h0;
    tick(6);
    run_cmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, `STSM_ST_CHECK);
    complete_run();
  end
endmodule : testbench
